// File: verilog/sirc_ctrl.v
// System interrupt gathering, reset sequencing and stop mode control
`include "sirc_consts.vh"
module sirc_ctrl (
    input wire clk,
    input wire resetn,
    input wire regWrEn,
    input wire regRdEn,
    input wire [3:0] regModule,
    input wire [3:0] regIndex,
    input wire [15:0] regWrData,
    output reg [15:0] regRdData,
    input wire [7:0] extIntPin,
    input wire [20:0] perEvent,
    input wire wdIntEvent,
    input wire wdResetReq,
    input wire coreSupplyOk,
    input wire resetPinIn,
    output wire resetPinOut,
    output wire resetPinOe,
    input wire xtalReady,
    input wire intAck,
    input wire returnFromService,
    output wire intRequest,
    output reg [15:0] intVector,
    output wire cpuHalt,
    output reg cpuRestart,
    output reg [15:0] fetchAddress,
    output reg runLoader,
    input wire tapLoaderSet,
    input wire tapLoaderClear,
    output reg loaderEnable,
    output wire xtalOscEnable,
    output wire rcOscEnable,
    output wire sysClkEnable,
    output reg clkFromRc,
    output wire tapEnable,
    output wire passwordLock,
    output wire wdResetEnable,
    output reg wdRestart,
    output wire [1:0] wdIntervalSel
);
    localparam [1:0] ST_RUN = 2'd0;
    localparam [1:0] ST_RESET = 2'd1;
    localparam [1:0] ST_STOP = 2'd2;
    localparam [1:0] ST_WARM = 2'd3;
    localparam integer RST_CNT_FULL = `SIRC_RST_CYCLES;
    localparam [3:0] RST_CNT_INIT = RST_CNT_FULL[3:0];

    function integer srcMod;
        input integer i;
        begin
            if (i < 8) srcMod = 0;
            else if (i < 10) srcMod = 1;
            else if (i < 21) srcMod = 2;
            else if (i < 24) srcMod = 3;
            else if (i < 26) srcMod = 4;
            else srcMod = 5;
        end
    endfunction

    function integer modBase;
        input integer m;
        begin
            case (m)
                0: modBase = 0;
                1: modBase = 8;
                2: modBase = 10;
                3: modBase = 21;
                4: modBase = 24;
                default: modBase = 26;
            endcase
        end
    endfunction

    reg [1:0] state_reg;
    reg [3:0] rstCnt_reg;
    reg internalRst_reg;
    reg [7:0] ictl_reg;
    reg [7:0] imask_reg;
    reg [7:0] sctl_reg;
    reg [7:0] clk_reg;
    reg [7:0] wdog_reg;
    reg [7:0] extRise_reg;
    reg pend_reg;
    reg [7:0] extS1_reg;
    reg [7:0] extS2_reg;
    reg [7:0] extPrev_reg;
    reg pinS1_reg;
    reg pinS2_reg;
    reg supS1_reg;
    reg supS2_reg;
    reg supPrev_reg;
    reg wakeS1_reg;
    reg wakeS2_reg;
    reg xtS1_reg;
    reg xtS2_reg;
    reg porFlag_reg;
    reg wdTrip_reg;
    reg hfOn_reg;

    wire [28:0] srcFlag;
    wire [28:0] srcEn;
    wire [7:0] extEdge;
    wire [28:0] srcEvt;
    wire porRise;
    wire extRstLow;
    wire inReset;
    wire inStop;
    wire wakeRaw;
    wire sysWr;
    wire wdFlagClr;
    reg [15:0] modFlags;
    reg [15:0] modEns;
    reg [5:0] modPend;
    reg [7:0] ident;
    reg [15:0] rdNext;
    integer i;

    // Two-flop synchronisers for pins and the supply detector
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            extS1_reg <= 8'h00;
            extS2_reg <= 8'h00;
            extPrev_reg <= 8'h00;
            pinS1_reg <= 1'b1;
            pinS2_reg <= 1'b1;
            supS1_reg <= 1'b0;
            supS2_reg <= 1'b0;
            supPrev_reg <= 1'b0;
            wakeS1_reg <= 1'b0;
            wakeS2_reg <= 1'b0;
            xtS1_reg <= 1'b0;
            xtS2_reg <= 1'b0;
        end else begin
            extS1_reg <= extIntPin;
            extS2_reg <= extS1_reg;
            extPrev_reg <= extS2_reg;
            pinS1_reg <= resetPinIn;
            pinS2_reg <= pinS1_reg;
            supS1_reg <= coreSupplyOk;
            supS2_reg <= supS1_reg;
            supPrev_reg <= supS2_reg;
            wakeS1_reg <= wakeRaw;
            wakeS2_reg <= wakeS1_reg;
            xtS1_reg <= xtalReady;
            xtS2_reg <= xtS1_reg;
        end
    end

    assign porRise = supS2_reg & ~supPrev_reg;
    assign extRstLow = ~pinS2_reg;
    assign inReset = (state_reg == ST_RESET);
    assign inStop = (state_reg == ST_STOP);
    assign extEdge = (extS2_reg & ~extPrev_reg & extRise_reg) |
        (~extS2_reg & extPrev_reg & ~extRise_reg);
    // Externals, serial, timers, CAN, ADC, brownouts, oscillator failure
    assign srcEvt = {perEvent, extEdge};
    assign sysWr = regWrEn && (regModule == `SIRC_MOD_SYS);

    // Stop exit path built from raw pins so it works with the clock halted
    assign wakeRaw = (|(srcEn[7:0] & (extIntPin ~^ extRise_reg))) | ~resetPinIn;
    assign xtalOscEnable = hfOn_reg & (~inStop | wakeRaw);
    assign rcOscEnable = ~inStop | wakeRaw;
    assign sysClkEnable = ~inStop | wakeRaw;
    assign cpuHalt = (state_reg != ST_RUN);

    // Internal resets pull the shared reset pin low
    assign resetPinOut = 1'b0;
    assign resetPinOe = internalRst_reg;

    // Per-source flag and enable bits
    genvar g;
    generate
        for (g = 0; g < `SIRC_NUM_SRC; g = g + 1) begin : srcGen
            localparam integer M = srcMod(g);
            localparam integer B = g - modBase(M);
            localparam [3:0] M4 = M[3:0];
            reg flagBit_reg;
            reg enBit_reg;
            wire hitFlags;
            wire hitEns;
            assign hitFlags = regWrEn && (regModule == M4) && (regIndex == `SIRC_IDX_FLAGS);
            assign hitEns = regWrEn && (regModule == M4) && (regIndex == `SIRC_IDX_ENABLE);
            always @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    flagBit_reg <= 1'b0;
                    enBit_reg <= 1'b0;
                end else if (inReset) begin
                    flagBit_reg <= 1'b0;
                    enBit_reg <= 1'b0;
                end else begin
                    // Event sets even when disabled; a set beats a clear
                    flagBit_reg <= srcEvt[g] | (flagBit_reg & ~(hitFlags & ~regWrData[B]));
                    if (hitEns) begin
                        enBit_reg <= regWrData[B];
                    end
                end
            end
            assign srcFlag[g] = flagBit_reg;
            assign srcEn[g] = enBit_reg;
        end
    endgenerate

    // Module view of flags, enables and pending requests
    always @* begin
        modFlags = 16'h0000;
        modEns = 16'h0000;
        modPend = 6'h00;
        for (i = 0; i < `SIRC_NUM_SRC; i = i + 1) begin
            if (srcMod(i) == regModule) begin
                modFlags[i - modBase(srcMod(i))] = srcFlag[i];
                modEns[i - modBase(srcMod(i))] = srcEn[i];
            end
            modPend[srcMod(i)] = modPend[srcMod(i)] | (srcFlag[i] & srcEn[i]);
        end
        ident = {wdog_reg[`SIRC_WD_IF_BIT] & wdog_reg[`SIRC_WD_EN_BIT], 1'b0, modPend};
    end

    // Registered request so a cleared flag drops the request next cycle
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pend_reg <= 1'b0;
        end else begin
            pend_reg <= |(ident & imask_reg);
        end
    end
    assign intRequest = pend_reg & ictl_reg[0] & ~ictl_reg[1] & (state_reg == ST_RUN);

    // Read answer, one cycle after the strobe
    always @* begin
        rdNext = 16'h0000;
        if (regModule == `SIRC_MOD_SYS) begin
            case (regIndex)
                `SIRC_IDX_ICTL: rdNext = {8'h00, ictl_reg};
                `SIRC_IDX_IMASK: rdNext = {8'h00, imask_reg};
                `SIRC_IDX_SCTL: rdNext = {8'h00, sctl_reg};
                `SIRC_IDX_IDENT: rdNext = {8'h00, ident};
                `SIRC_IDX_CLK: rdNext = {8'h00, clk_reg[7], hfOn_reg, clkFromRc, clk_reg[4:0]};
                `SIRC_IDX_WDOG: rdNext = {8'h00, porFlag_reg, wdog_reg[6:3], wdTrip_reg,
                    wdog_reg[1:0]};
                default: rdNext = 16'h0000;
            endcase
        end else if (regModule == `SIRC_MOD_STK) begin
            if (regIndex == `SIRC_IDX_IVEC) begin
                rdNext = intVector;
            end
        end else if (regIndex == `SIRC_IDX_FLAGS) begin
            rdNext = modFlags;
        end else if (regIndex == `SIRC_IDX_ENABLE) begin
            rdNext = modEns;
        end else if (regIndex == `SIRC_IDX_EDGE && regModule == 4'h0) begin
            rdNext = {8'h00, extRise_reg};
        end
    end

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            regRdData <= 16'h0000;
        end else if (regRdEn) begin
            regRdData <= rdNext;
        end
    end

    // Software registers; every reset source returns them to defaults
    assign wdFlagClr = sysWr && (regIndex == `SIRC_IDX_WDOG) && !regWrData[`SIRC_WD_IF_BIT];
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ictl_reg <= 8'h00;
            imask_reg <= 8'h00;
            sctl_reg <= `SIRC_SCTL_RST;
            clk_reg <= 8'h00;
            wdog_reg <= 8'h00;
            extRise_reg <= 8'h00;
            intVector <= `SIRC_IVEC_RST;
            wdRestart <= 1'b0;
        end else if (inReset) begin
            ictl_reg <= 8'h00;
            imask_reg <= 8'h00;
            sctl_reg <= `SIRC_SCTL_RST;
            clk_reg <= 8'h00;
            wdog_reg <= 8'h00;
            extRise_reg <= 8'h00;
            intVector <= `SIRC_IVEC_RST;
            wdRestart <= 1'b0;
        end else begin
            wdRestart <= sysWr && (regIndex == `SIRC_IDX_WDOG) && regWrData[0];
            if (sysWr && regIndex == `SIRC_IDX_ICTL) begin
                ictl_reg <= regWrData[7:0] & `SIRC_ICTL_MASK;
            end else if (intAck && intRequest) begin
                ictl_reg[1] <= 1'b1;
            end else if (returnFromService) begin
                ictl_reg[1] <= 1'b0;
            end
            if (sysWr && regIndex == `SIRC_IDX_IMASK) begin
                imask_reg <= regWrData[7:0] & `SIRC_IMASK_MASK;
            end
            if (sysWr && regIndex == `SIRC_IDX_SCTL) begin
                sctl_reg <= regWrData[7:0] & `SIRC_SCTL_MASK;
            end
            if (sysWr && regIndex == `SIRC_IDX_CLK) begin
                clk_reg[`SIRC_CLK_STOP_BIT] <= regWrData[`SIRC_CLK_STOP_BIT];
                clk_reg[`SIRC_CLK_RESUME_RC_BIT] <= regWrData[`SIRC_CLK_RESUME_RC_BIT];
                clk_reg[0] <= regWrData[0];
            end else if (inStop && wakeS2_reg) begin
                clk_reg[`SIRC_CLK_STOP_BIT] <= 1'b0;
            end
            clk_reg[7] <= xtS2_reg;
            if (sysWr && regIndex == `SIRC_IDX_WDOG) begin
                wdog_reg[6:4] <= regWrData[6:4];
                wdog_reg[1] <= regWrData[1];
            end
            wdog_reg[`SIRC_WD_IF_BIT] <= wdIntEvent |
                (wdog_reg[`SIRC_WD_IF_BIT] & ~wdFlagClr);
            if (regWrEn && regModule == `SIRC_MOD_STK && regIndex == `SIRC_IDX_IVEC) begin
                intVector <= regWrData;
            end
            if (regWrEn && regModule == 4'h0 && regIndex == `SIRC_IDX_EDGE) begin
                extRise_reg <= regWrData[7:0];
            end
        end
    end
    assign tapEnable = sctl_reg[7];
    assign passwordLock = sctl_reg[1];
    assign wdResetEnable = wdog_reg[1];
    assign wdIntervalSel = wdog_reg[5:4];

    // Reset cause flags and clock source, kept across non power-on resets
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            porFlag_reg <= 1'b1;
            wdTrip_reg <= 1'b0;
            hfOn_reg <= 1'b0;
            clkFromRc <= 1'b1;
            loaderEnable <= 1'b0;
        end else begin
            if (porRise) begin
                porFlag_reg <= 1'b1;
                hfOn_reg <= 1'b0;
                clkFromRc <= 1'b1;
            end else begin
                if (sysWr && regIndex == `SIRC_IDX_WDOG && !regWrData[7]) begin
                    porFlag_reg <= 1'b0;
                end
                if (sysWr && regIndex == `SIRC_IDX_CLK) begin
                    hfOn_reg <= regWrData[`SIRC_CLK_HFON_BIT];
                end
                if (state_reg == ST_RUN && sysWr && regIndex == `SIRC_IDX_CLK) begin
                    clkFromRc <= regWrData[`SIRC_CLK_RC_BIT] | ~xtS2_reg;
                end else if (inStop && wakeS2_reg && hfOn_reg && !clkFromRc &&
                    clk_reg[`SIRC_CLK_RESUME_RC_BIT]) begin
                    clkFromRc <= 1'b1;
                end
            end
            if (wdResetReq) begin
                wdTrip_reg <= 1'b1;
            end else if (sysWr && regIndex == `SIRC_IDX_WDOG && !regWrData[2]) begin
                wdTrip_reg <= 1'b0;
            end
            if (inReset && tapLoaderSet) begin
                loaderEnable <= 1'b1;
            end else if (tapLoaderClear) begin
                loaderEnable <= 1'b0;
            end
        end
    end

    // Sequencer: run, reset, stop and crystal warm-up
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= ST_RESET;
            rstCnt_reg <= RST_CNT_INIT;
            internalRst_reg <= 1'b1;
            cpuRestart <= 1'b0;
            fetchAddress <= `SIRC_START_ADDR;
            runLoader <= 1'b0;
        end else begin
            cpuRestart <= 1'b0;
            if (porRise || wdResetReq) begin
                state_reg <= ST_RESET;
                rstCnt_reg <= RST_CNT_INIT;
                internalRst_reg <= 1'b1;
            end else if (extRstLow && !internalRst_reg) begin
                state_reg <= ST_RESET;
            end else begin
                case (state_reg)
                    ST_RESET: begin
                        if (rstCnt_reg != 4'h0) begin
                            rstCnt_reg <= rstCnt_reg - 4'h1;
                        end else begin
                            internalRst_reg <= 1'b0;
                            if (!extRstLow && !internalRst_reg) begin
                                state_reg <= ST_RUN;
                                cpuRestart <= 1'b1;
                                fetchAddress <= `SIRC_START_ADDR;
                                runLoader <= loaderEnable;
                            end
                        end
                    end
                    ST_RUN: begin
                        if (clk_reg[`SIRC_CLK_STOP_BIT]) begin
                            state_reg <= ST_STOP;
                        end
                    end
                    ST_STOP: begin
                        if (wakeS2_reg) begin
                            if (hfOn_reg && !clkFromRc && !clk_reg[`SIRC_CLK_RESUME_RC_BIT]) begin
                                state_reg <= ST_WARM;
                            end else begin
                                state_reg <= ST_RUN;
                            end
                        end
                    end
                    ST_WARM: begin
                        if (xtS2_reg) begin
                            state_reg <= ST_RUN;
                        end
                    end
                    default: state_reg <= ST_RESET;
                endcase
            end
        end
    end
endmodule

// File: verilog/sirc_consts.vh
// Constants for the system interrupt and reset control block
`ifndef SIRC_CONSTS_VH
`define SIRC_CONSTS_VH
`define SIRC_MOD_SYS 4'h8
`define SIRC_MOD_STK 4'hD
`define SIRC_IDX_ICTL 4'h5
`define SIRC_IDX_IMASK 4'h6
`define SIRC_IDX_SCTL 4'h8
`define SIRC_IDX_IDENT 4'hB
`define SIRC_IDX_CLK 4'hE
`define SIRC_IDX_WDOG 4'hF
`define SIRC_IDX_IVEC 4'h2
`define SIRC_IDX_FLAGS 4'h0
`define SIRC_IDX_ENABLE 4'h1
`define SIRC_IDX_EDGE 4'h2
`define SIRC_NUM_SRC 29
`define SIRC_NUM_MOD 6
`define SIRC_IVEC_RST 16'h0000
`define SIRC_START_ADDR 16'h8000
`define SIRC_SCTL_RST 8'h82
`define SIRC_SCTL_MASK 8'hBE
`define SIRC_ICTL_MASK 8'h21
`define SIRC_IMASK_MASK 8'hBF
`define SIRC_WD_EN_BIT 6
`define SIRC_WD_IF_BIT 3
`define SIRC_CLK_RC_BIT 5
`define SIRC_CLK_STOP_BIT 4
`define SIRC_CLK_RESUME_RC_BIT 3
`define SIRC_CLK_HFON_BIT 6
`define SIRC_CLK_NS 50
`define SIRC_RST_STRETCH_NS 500
`define SIRC_RST_CYCLES ((`SIRC_RST_STRETCH_NS + `SIRC_CLK_NS - 1) / `SIRC_CLK_NS)
`endif

// File: verification/sirc_ctrl_properties.sv
// Port assertions for the interrupt and reset control block
module sirc_ctrl_properties (
    input wire clk,
    input wire resetn,
    input wire wdResetReq,
    input wire resetPinIn,
    input wire resetPinOe,
    input wire intRequest,
    input wire intAck,
    input wire [15:0] intVector,
    input wire cpuHalt,
    input wire cpuRestart,
    input wire [15:0] fetchAddress,
    input wire runLoader,
    input wire xtalOscEnable,
    input wire rcOscEnable,
    input wire sysClkEnable,
    input wire clkFromRc
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    a_stretch_pin_low: assert property ($rose(resetn) |-> resetPinOe [*8])
        else $error("reset pin released early");
    a_por_defaults: assert property ($rose(resetn) |-> intVector == 16'h0000
        && clkFromRc && !xtalOscEnable && cpuHalt) else $error("power-on defaults wrong");
    a_restart_fetch: assert property (cpuRestart |-> fetchAddress == 16'h8000
        ##1 !cpuRestart) else $error("restart address or pulse wrong");
    a_stop_quiet: assert property (!sysClkEnable |-> cpuHalt && !rcOscEnable
        && !xtalOscEnable) else $error("stop state not quiet");
    a_pin_wakes: assert property (!resetPinIn |-> sysClkEnable && rcOscEnable)
        else $error("reset pin did not wake");
    a_reset_halts: assert property (resetPinOe |-> cpuHalt && rcOscEnable && !intRequest)
        else $error("reset state wrong");
    a_request_run: assert property (intRequest |-> !cpuHalt && sysClkEnable)
        else $error("request while halted");
    a_ack_drops: assert property (intRequest && intAck |=> !intRequest)
        else $error("request kept after acceptance");
    a_wd_reset: assert property (wdResetReq && !cpuHalt |-> ##[1:3] resetPinOe)
        else $error("watchdog reset not driven");
    a_loader_steady: assert property (!cpuHalt && !$past(cpuHalt) && !cpuRestart
        && !$past(cpuRestart) |-> $stable(runLoader)) else $error("loader mode changed");
    c_restart: cover property (cpuRestart);
    c_taken: cover property (intRequest && intAck);
    c_stop: cover property (!sysClkEnable);
endmodule
bind sirc_ctrl sirc_ctrl_properties sirc_ctrl_properties_inst (.*);

// File: verification/sirc_far_end.sv
// Far side: reset pin with pull-up, test port loader pulses, crystal warm-up
module sirc_far_end #(
    parameter WARM_CYCLES = 20
) (
    input wire clk,
    input wire holdReset,
    input wire loaderReq,
    input wire loaderDrop,
    input wire resetPinOut,
    input wire resetPinOe,
    input wire xtalOscEnable,
    output wire resetPinIn,
    output reg tapLoaderSet,
    output reg tapLoaderClear,
    output wire xtalReady
);
    timeunit 1ns;
    timeprecision 1ns;
    integer warm = 0;
    // Pull-up holds the pin high unless a party pulls it low
    assign resetPinIn = !(holdReset || (resetPinOe && !resetPinOut));
    assign xtalReady = warm >= WARM_CYCLES;
    always @(posedge clk) begin
        tapLoaderSet <= loaderReq;
        tapLoaderClear <= loaderDrop;
        warm <= xtalOscEnable ? warm + 1 : 0;
    end
endmodule

// File: verification/sirc_ctrl_tb_top.sv
// Self-checking bench for the interrupt and reset control block
module sirc_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    reg clk = 0, resetn = 0, regWrEn = 0, regRdEn = 0, wdIntEvent = 0, wdResetReq = 0;
    reg coreSupplyOk = 1, intAck = 0, returnFromService = 0, holdReset = 0;
    reg loaderReq = 0, loaderDrop = 0;
    reg [3:0] regModule = 4'h0, regIndex = 4'h0;
    reg [15:0] regWrData = 16'h0000, rnd = 16'h001C, rdv;
    reg [7:0] extIntPin = 8'hFF;
    reg [20:0] perEvent = 21'h0;
    wire resetPinIn, resetPinOut, resetPinOe, xtalReady, tapLoaderSet, tapLoaderClear;
    wire intRequest, cpuHalt, cpuRestart, runLoader, loaderEnable, xtalOscEnable, rcOscEnable;
    wire sysClkEnable, clkFromRc, tapEnable, passwordLock, wdResetEnable, wdRestart;
    wire [15:0] regRdData, intVector, fetchAddress;
    wire [1:0] wdIntervalSel;
    integer failures = 0, total_checks = 0, n, k, m;
    integer modelFlags [0:5];
    integer evq [$];
    sirc_ctrl sirc_ctrl_inst (.*);
    sirc_far_end sirc_far_end_inst (.*);
    initial forever #25 clk = ~clk;
    function [15:0] lfsr(input [15:0] s);
        lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function integer modOf(input integer b);
        modOf = b < 2 ? 1 : b < 13 ? 2 : b < 16 ? 3 : b < 18 ? 4 : 5;
    endfunction
    function integer bitOf(input integer b);
        bitOf = b < 2 ? b : b < 13 ? b - 2 : b < 16 ? b - 13 : b < 18 ? b - 16 : b - 18;
    endfunction
    task check(input string what, input [15:0] seen, input [15:0] exp);
        total_checks = total_checks + 1;
        if (seen !== exp) begin
            failures = failures + 1;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task complete_run;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task bus(input w, input [3:0] md, input [3:0] x, input [15:0] d);
        @(posedge clk);
        regWrEn <= w;
        regRdEn <= !w;
        regModule <= md;
        regIndex <= x;
        regWrData <= d;
        @(posedge clk);
        regWrEn <= 1'h0;
        regRdEn <= 1'h0;
        #1 rdv = regRdData;
    endtask
    task waitRun;
        n = 0;
        while (cpuHalt !== 1'b0 && n < 300) begin
            @(posedge clk);
            #1 n = n + 1;
        end
        if (n == 300) begin
            failures = failures + 1;
            complete_run;
        end
    endtask
    task extReset;
        @(posedge clk) holdReset <= 1'h1;
        repeat (4) @(posedge clk);
        #1 check("halt", cpuHalt, 1);
        check("rcosc", rcOscEnable, 1);
        check("pinoe", resetPinOe, 0);
    endtask
    initial begin
        #4000000 failures = failures + 1;
        complete_run;
    end
    initial begin
        repeat (10) @(posedge clk);
        resetn <= 1'h1;
        waitRun;
        check("fetch", fetchAddress, 16'h8000);
        check("rcsel", clkFromRc, 1);
        check("xtal", xtalOscEnable, 0);
        check("vector", intVector, 0);
        check("loader", runLoader, 0);
        check("tapen", tapEnable, 1);
        check("pwlock", passwordLock, 1);
        check("wdrst", wdResetEnable, 0);
        check("wdsel", wdIntervalSel, 0);
        check("wdpulse", wdRestart, 0);
        bus(0, 8, 4'hF, 0);
        check("powerup", rdv[7], 1);
        bus(0, 8, 8, 0);
        check("sysctl", rdv, 16'h0082);
        rnd = lfsr(rnd);
        bus(1, 4'hD, 2, rnd);
        bus(0, 4'hD, 2, 0);
        check("vecrd", rdv, rnd);
        check("vecport", intVector, rnd);
        bus(0, 8, 3, 0);
        check("unmapped", rdv, 0);
        for (k = 0; k < 6; k = k + 1) modelFlags[k] = 0;
        repeat (30) begin
            rnd = lfsr(rnd);
            @(posedge clk) perEvent <= 21'h1 << (rnd % 21);
            evq.push_back(rnd % 21);
        end
        @(posedge clk) perEvent <= 21'h0;
        while (evq.size() > 0) begin
            k = evq.pop_front();
            m = modOf(k);
            modelFlags[m] = modelFlags[m] | (1 << bitOf(k));
        end
        for (k = 1; k < 6; k = k + 1) begin
            bus(0, k, 0, 0);
            check("flags", rdv, modelFlags[k]);
        end
        check("noreq", intRequest, 0);
        @(posedge clk) extIntPin <= 8'h00;
        repeat (5) @(posedge clk);
        bus(0, 0, 0, 0);
        check("extflags", rdv, 16'h00FF);
        @(posedge clk) extIntPin <= 8'hFF;
        @(posedge clk) wdIntEvent <= 1'h1;
        @(posedge clk) wdIntEvent <= 1'h0;
        bus(0, 8, 4'hF, 0);
        check("wdflag", rdv[3], 1);
        bus(1, 8, 4'hF, 0);
        for (k = 0; k < 6; k = k + 1) bus(1, k, 0, 0);
        @(posedge clk) perEvent <= 21'h1;
        @(posedge clk) perEvent <= 21'h0;
        bus(1, 1, 1, 16'h0001);
        bus(1, 8, 6, 16'h0002);
        check("globaloff", intRequest, 0);
        bus(1, 8, 5, 16'h0001);
        repeat (2) @(posedge clk);
        #1 check("req", intRequest, 1);
        bus(0, 8, 4'hB, 0);
        check("ident", rdv, 16'h0002);
        @(posedge clk) intAck <= 1'h1;
        @(posedge clk) intAck <= 1'h0;
        @(posedge clk) returnFromService <= 1'h1;
        @(posedge clk) returnFromService <= 1'h0;
        @(posedge clk);
        #1 check("reqback", intRequest, 1);
        bus(1, 1, 0, 0);
        repeat (2) @(posedge clk);
        #1 check("withdraw", intRequest, 0);
        bus(1, 0, 1, 16'h0001);
        bus(1, 8, 6, 16'h0003);
        bus(1, 8, 4'hE, 16'h0038);
        repeat (2) @(posedge clk);
        #1 check("stopclk", sysClkEnable, 0);
        @(posedge clk) extIntPin <= 8'hFD;
        repeat (3) @(posedge clk);
        #1 check("nowake", sysClkEnable, 0);
        @(posedge clk) extIntPin <= 8'hFC;
        @(posedge clk);
        #1 check("wake", sysClkEnable, 1);
        waitRun;
        check("resumerc", clkFromRc, 1);
        @(posedge clk) extIntPin <= 8'hFF;
        bus(1, 8, 4'hE, 16'h0060);
        check("hfon", xtalOscEnable, 1);
        @(posedge clk) wdResetReq <= 1'h1;
        @(posedge clk) wdResetReq <= 1'h0;
        repeat (3) @(posedge clk);
        #1 check("wdpin", resetPinOe, 1);
        waitRun;
        check("wdfetch", fetchAddress, 16'h8000);
        bus(0, 8, 4'hF, 0);
        check("wdcause", rdv & 16'h0084, 16'h0004);
        check("wdxtal", xtalOscEnable, 1);
        check("wdvec", intVector, 0);
        extReset;
        @(posedge clk) loaderReq <= 1'h1;
        @(posedge clk) loaderReq <= 1'h0;
        @(posedge clk) holdReset <= 1'h0;
        waitRun;
        check("ldrun", runLoader, 1);
        check("ldset", loaderEnable, 1);
        @(posedge clk) loaderDrop <= 1'h1;
        @(posedge clk) loaderDrop <= 1'h0;
        extReset;
        @(posedge clk) holdReset <= 1'h0;
        waitRun;
        check("ldskip", runLoader, 0);
        check("ldclr", loaderEnable, 0);
        check("extfetch", fetchAddress, 16'h8000);
        bus(1, 0, 1, 16'h0001);
        bus(1, 8, 4'hE, 16'h0050);
        repeat (6) @(posedge clk);
        @(posedge clk) extIntPin <= 8'hFE;
        repeat (6) @(posedge clk);
        #1 check("warmwait", cpuHalt, 1);
        waitRun;
        check("xtalrun", clkFromRc, 0);
        @(posedge clk) extIntPin <= 8'hFF;
        bus(1, 8, 4'hE, 16'h0058);
        repeat (2) @(posedge clk);
        @(posedge clk) extIntPin <= 8'hFE;
        waitRun;
        check("rcresume", clkFromRc, 1);
        check("xtalwarms", xtalOscEnable, 1);
        @(posedge clk) extIntPin <= 8'hFF;
        @(posedge clk) coreSupplyOk <= 1'h0;
        repeat (4) @(posedge clk);
        coreSupplyOk <= 1'h1;
        repeat (4) @(posedge clk);
        waitRun;
        check("supxtal", xtalOscEnable, 0);
        bus(0, 8, 4'hF, 0);
        check("suppor", rdv[7], 1);
        bus(1, 8, 4'hE, 16'h0060);
        check("hfagain", xtalOscEnable, 1);
        @(posedge clk) resetn <= 1'h0;
        repeat (3) @(posedge clk);
        resetn <= 1'h1;
        waitRun;
        check("porxtal", xtalOscEnable, 0);
        check("porrc", clkFromRc, 1);
        complete_run;
    end
endmodule
